/* File: core/crf_core.sv */
/*
 * Datapath core: program counter, two-stage fetch/execute pipeline,
 * operand selection, write-back, return stack and interrupt priority.
 * Assumes the external decoder and ALU answer combinationally within the
 * cycle, and program memory answers PM_ADDR within the same cycle.
 */
// Operation
// [RL1] 32 registers of 8 bits, single-cycle access.
// [RL2] Read two, compute, write back in one cycle; OPA and OPB are registered, so operands reach the ALU one cycle after the read.
// [RL3] Registers 30 and 31 form 16-bit pointer.
// [RL4] Register-file pointer access ignores register 31.
// [RL5] Immediate instructions target registers 16 to 31.
// [RL6] Register instructions reach all 32 registers.
// [RL7] Fetch next instruction while executing current one.
// [RL8] Each instruction is one 16-bit word.
// [RL9] 9-bit program counter over 512 words.
// [RL10] Relative jumps and calls reach all addresses.
// [RL11] Calls and interrupts push return address.
// [RL12] Lower interrupt vector wins priority.
// [RL13] Global enable gates all interrupts.
// [RL14] I/O space of 64 locations.
// [RL15] Stack push shifts deeper, pop shifts up.
// [RL16] Fourth push loses oldest; deepest returns twice.
// [RL17] Interrupt entry clears global enable; return sets it.
// [RL18] Indirect access uses pointer low byte.
// [RL19] Two asynchronous reads, one synchronous write.
// [RL20] Flow change discards the prefetched instruction.
`timescale 1ns/1ns
`default_nettype none
module crf_core
	import crf_pkg::*;
(
	input wire logic CLK_SYS, // 10 MHz system clock.
	input wire logic RST, // Synchronous reset, active high.
	input wire logic CE, // Clock enable; low freezes all state.
	input wire logic [INSN_W-1:0] PM_DATA, // Program word at PM_ADDR.
	input wire logic [1:0] DEC_SRC_A, // Operand A source (crf_src_t).
	input wire logic [RADDR_W-1:0] DEC_RD, // Destination register.
	input wire logic [RADDR_W-1:0] DEC_RR, // Second source register.
	input wire logic DEC_IMM, // Immediate-operand instruction.
	input wire logic DEC_WE, // Result is written back.
	input wire logic [2:0] DEC_FLOW, // Program flow (crf_flow_t).
	input wire logic [11:0] DEC_K, // Signed relative offset.
	input wire logic [REG_W-1:0] ALU_RESULT, // ALU result.
	input wire logic [IRQ_N-1:0] IRQ_REQ, // Pending masked sources.
	input wire logic GIE_SET, // Software sets global enable.
	input wire logic GIE_CLR, // Software clears global enable.
	output logic [PC_W-1:0] PM_ADDR, // Program memory address.
	output logic [INSN_W-1:0] INSN, // Instruction in execute.
	output logic INSN_VALID, // Execute stage holds a live word.
	output logic [REG_W-1:0] OPA, // Operand A to ALU.
	output logic [REG_W-1:0] OPB, // Operand B to ALU.
	output logic [15:0] PTR, // Indirect pointer value.
	output logic [IO_AW-1:0] IO_PTR, // Pointer as I/O address.
	output logic [PC_W-1:0] PC_OUT, // Program counter.
	output logic GIE, // Global interrupt enable.
	output logic IRQ_TAKEN // Interrupt entry pulse.
);
	crf_rf_if rf ();
	crf_flow_t flow;
	crf_src_t src_a;
	logic [PC_W-1:0] pc_q, pc_d, exec_pc_q, stk_top, push_addr;
	logic [INSN_W-1:0] insn_q;
	logic valid_q, gie_q, taken_q, redirect, irq_go, push, pop;
	logic [PC_W-1:0] vec_addr;
	logic [RADDR_W-1:0] wa_eff;
	logic [REG_W-1:0] opa_q, opb_q;
	logic [PC_W-1:0] rel_tgt;

	assign flow = crf_flow_t'(DEC_FLOW);
	assign src_a = crf_src_t'(DEC_SRC_A);

	crf_regs u_regs (
		.clk(CLK_SYS),
		.rst(RST),
		.rf(rf)
	);

	crf_stack u_stack (
		.clk(CLK_SYS),
		.rst(RST),
		.ce(CE),
		.push(push),
		.pop(pop),
		.din(push_addr),
		.top(stk_top)
	);

	// Lowest pending vector number wins.
	always_comb begin
		vec_addr = PC_RESET;
		for (int i = IRQ_N-1; i >= 0; i--) begin
			if (IRQ_REQ[i]) begin
				vec_addr = PC_W'(i + 1); // [RL12]
			end
		end
	end

	assign irq_go = gie_q && (|IRQ_REQ) && valid_q; // [RL13]

	// Offset is cut to the counter width, so the sum wraps. [RL10]
	assign rel_tgt = exec_pc_q + DEC_K[PC_W-1:0] + PC_W'(1);

	always_comb begin
		redirect = 1'b0;
		pc_d = pc_q + PC_W'(1);
		push = 1'b0;
		pop = 1'b0;
		push_addr = exec_pc_q + PC_W'(1);
		if (irq_go) begin
			redirect = 1'b1;
			pc_d = vec_addr;
			push = 1'b1; // [RL11]
			push_addr = exec_pc_q;
		end else if (valid_q) begin
			case (flow)
				CRF_OP_JUMP: begin
					redirect = 1'b1;
					pc_d = rel_tgt;
				end
				CRF_OP_CALL: begin
					redirect = 1'b1;
					pc_d = rel_tgt;
					push = 1'b1; // [RL11]
				end
				CRF_OP_RET, CRF_OP_RETURN_FROM_IRQ: begin
					redirect = 1'b1;
					pc_d = stk_top;
					pop = 1'b1; // [RL15]
				end
				default: begin
				end
			endcase
		end
	end

	// Fetch runs one word ahead of execute. [RL7] [RL9]
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pc_q <= PC_RESET;
			exec_pc_q <= PC_RESET;
		end else if (CE) begin
			pc_q <= pc_d;
			exec_pc_q <= pc_q;
		end
	end

	// A redirect squashes the word already fetched. [RL20] [RL8]
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			insn_q <= INSN_NOP;
			valid_q <= 1'b0;
		end else if (CE) begin
			insn_q <= redirect ? INSN_NOP : PM_DATA;
			valid_q <= !redirect;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			gie_q <= GIE_RESET;
			taken_q <= 1'b0;
		end else if (CE) begin
			taken_q <= irq_go;
			if (irq_go) begin
				gie_q <= 1'b0; // [RL17]
			end else if (valid_q && flow == CRF_OP_RETURN_FROM_IRQ) begin
				gie_q <= 1'b1; // [RL17]
			end else if (GIE_SET) begin
				gie_q <= 1'b1; // [RL13]
			end else if (GIE_CLR) begin
				gie_q <= 1'b0;
			end
		end
	end

	// Indirect reads use only the low pointer byte. [RL4] [RL18]
	always_comb begin
		rf.rb_addr = DEC_RR; // [RL6]
		if (src_a == CRF_SRC_IND) begin
			rf.ra_addr = rf.ptr_lo[RADDR_W-1:0];
		end else if (DEC_IMM) begin
			rf.ra_addr = IMM_BASE_IDX | DEC_RD; // [RL5]
		end else begin
			rf.ra_addr = DEC_RD; // [RL6]
		end
	end

	assign wa_eff = DEC_IMM ? (IMM_BASE_IDX | DEC_RD) : DEC_RD; // [RL5]
	assign rf.wa = wa_eff;
	assign rf.wd = ALU_RESULT;
	// Write-back lands at the end of the execute cycle. [RL2]
	assign rf.we = CE && valid_q && DEC_WE && !irq_go;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			opa_q <= REG_RESET;
			opb_q <= REG_RESET;
		end else if (CE) begin
			opa_q <= rf.ra_data;
			opb_q <= rf.rb_data;
		end
	end

	assign PM_ADDR = pc_q;
	assign PC_OUT = exec_pc_q;
	assign INSN = insn_q;
	assign INSN_VALID = valid_q;
	assign OPA = opa_q;
	assign OPB = opb_q;
	assign GIE = gie_q;
	assign IRQ_TAKEN = taken_q;

	// Pointer outputs are registered copies of registers 30 and 31. [RL3]
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			PTR <= {REG_RESET, REG_RESET};
			IO_PTR <= IO_AW'(0);
		end else if (CE) begin
			PTR <= {rf.ptr_hi, rf.ptr_lo};
			IO_PTR <= rf.ptr_lo[IO_AW-1:0]; // [RL14]
		end
	end
endmodule : crf_core
`default_nettype wire

/* File: core/crf_regs.sv */
/*
 * Working register file: 32 entries of 8 bits, two read ports and one
 * clocked write port, with the pointer pair exposed directly.
 * Assumes the core holds the write enable low while it is frozen.
 */
`timescale 1ns/1ns
`default_nettype none
module crf_regs
	import crf_pkg::*;
(
	input wire logic clk, // System clock.
	input wire logic rst, // Synchronous reset.
	crf_rf_if.store rf // Register-file port.
);
	logic [REG_W-1:0] mem_q [REG_COUNT];

	genvar g;
	generate
		for (g = 0; g < REG_COUNT; g++) begin : g_ent
			always_ff @(posedge clk) begin
				if (rst) begin
					mem_q[g] <= REG_RESET;
				end else if (rf.we && rf.wa == RADDR_W'(g)) begin
					mem_q[g] <= rf.wd; // [RL1] [RL2]
				end
			end
		end
	endgenerate

	assign rf.ra_data = mem_q[rf.ra_addr]; // [RL19]
	assign rf.rb_data = mem_q[rf.rb_addr]; // [RL19]
	assign rf.ptr_lo = mem_q[PTR_LO_IDX]; // [RL3]
	assign rf.ptr_hi = mem_q[PTR_HI_IDX]; // [RL3]
endmodule : crf_regs
`default_nettype wire

/* File: core/crf_stack.sv */
/*
 * Three-level return-address stack of 9-bit entries. A push shifts the
 * entries deeper and drops the oldest; a pop shifts them up and keeps the
 * deepest value, so it can be returned twice.
 * Assumes push and pop are never requested together.
 */
`timescale 1ns/1ns
`default_nettype none
module crf_stack
	import crf_pkg::*;
(
	input wire logic clk, // System clock.
	input wire logic rst, // Synchronous reset.
	input wire logic ce, // Clock enable.
	input wire logic push, // Push request.
	input wire logic pop, // Pop request.
	input wire logic [PC_W-1:0] din, // Return address to push.
	output logic [PC_W-1:0] top // Level 0, registered.
);
	logic [PC_W-1:0] lvl_q [STACK_DEPTH];

	genvar g;
	generate
		for (g = 0; g < STACK_DEPTH; g++) begin : g_lvl
			always_ff @(posedge clk) begin
				if (rst) begin
					lvl_q[g] <= PC_RESET;
				end else if (ce && push) begin
					lvl_q[g] <= (g == 0) ? din : lvl_q[(g == 0) ? 0 : g-1]; // [RL15] [RL16]
				end else if (ce && pop && g < STACK_DEPTH-1) begin
					lvl_q[g] <= lvl_q[(g < STACK_DEPTH-1) ? g+1 : g]; // [RL15] [RL16]
				end
			end
		end
	endgenerate

	assign top = lvl_q[0];
endmodule : crf_stack
`default_nettype wire

/* File: inc/crf_pkg.sv */
/*
 * Package for the CPU datapath core: register file, pointer, return
 * stack, pipeline and interrupt constants.
 * Assumes it is compiled before every other file of the block.
 */
`default_nettype none
package crf_pkg;
	localparam int REG_COUNT = 32;
	localparam int REG_W = 8;
	localparam int RADDR_W = 5;
	localparam int INSN_W = 16;
	localparam int PC_W = 9;
	localparam int STACK_DEPTH = 3;
	localparam int IRQ_N = 8;
	localparam int IO_AW = 6;
	localparam logic [4:0] PTR_LO_IDX = 5'h1E;
	localparam logic [4:0] PTR_HI_IDX = 5'h1F;
	localparam logic [4:0] IMM_BASE_IDX = 5'h10;
	localparam logic [8:0] PC_RESET = 9'h000;
	localparam logic [15:0] INSN_NOP = 16'h0000;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic GIE_RESET = 1'b0;

	typedef enum logic [2:0] {
		CRF_OP_SEQ,
		CRF_OP_JUMP,
		CRF_OP_CALL,
		CRF_OP_RET,
		CRF_OP_RETURN_FROM_IRQ
	} crf_flow_t;

	typedef enum logic [1:0] {
		CRF_SRC_REG,
		CRF_SRC_IMM,
		CRF_SRC_IND
	} crf_src_t;
endpackage : crf_pkg
`default_nettype wire

/* File: inc/crf_rf_if.sv */
/*
 * Interface carrying the register-file ports between the core and its
 * storage module.
 * Assumes a single clock shared by both ends.
 */
`timescale 1ns/1ns
`default_nettype none
interface crf_rf_if;
	import crf_pkg::*;
	logic [RADDR_W-1:0] ra_addr;
	logic [RADDR_W-1:0] rb_addr;
	logic [REG_W-1:0] ra_data;
	logic [REG_W-1:0] rb_data;
	logic [REG_W-1:0] ptr_lo;
	logic [REG_W-1:0] ptr_hi;
	logic we;
	logic [RADDR_W-1:0] wa;
	logic [REG_W-1:0] wd;
	modport core (output ra_addr, output rb_addr, input ra_data,
		input rb_data, input ptr_lo, input ptr_hi, output we,
		output wa, output wd);
	modport store (input ra_addr, input rb_addr, output ra_data,
		output rb_data, output ptr_lo, output ptr_hi, input we,
		input wa, input wd);
endinterface : crf_rf_if
`default_nettype wire

/* File: testbench/crf_core_properties.sv */
/* Port assertions for the datapath core.
   Assumes it is bound into every crf_core instance. */
`timescale 1ns/1ns
`default_nettype none
module crf_core_props
	import crf_pkg::*;
(
	input wire logic CLK_SYS, // Clock.
	input wire logic RST, // Reset.
	input wire logic CE, // Enable.
	input wire logic [RADDR_W-1:0] DEC_RD, // Target.
	input wire logic [RADDR_W-1:0] DEC_RR, // Source.
	input wire logic DEC_IMM, // Immediate.
	input wire logic DEC_WE, // Write.
	input wire logic [2:0] DEC_FLOW, // Flow.
	input wire logic [11:0] DEC_K, // Offset.
	input wire logic [REG_W-1:0] ALU_RESULT, // Result.
	input wire logic [IRQ_N-1:0] IRQ_REQ, // Requests.
	input wire logic GIE_SET, // Enable set.
	input wire logic [PC_W-1:0] PM_ADDR, // Fetch.
	input wire logic [INSN_W-1:0] INSN, // Word.
	input wire logic INSN_VALID, // Live.
	input wire logic [REG_W-1:0] OPB, // Operand.
	input wire logic [15:0] PTR, // Pointer.
	input wire logic [IO_AW-1:0] IO_PTR, // I/O pointer.
	input wire logic [PC_W-1:0] PC_OUT, // Counter.
	input wire logic GIE, // Enable.
	input wire logic IRQ_TAKEN // Entry.
);
	logic irq_go;
	logic run;
	logic [PC_W-1:0] vec;
	logic [PC_W-1:0] koff;
	logic [RADDR_W-1:0] wa;
	assign irq_go = GIE && IRQ_REQ != '0;
	assign run = CE && INSN_VALID && !irq_go && !GIE_SET;
	assign koff = DEC_K[PC_W-1:0];
	assign wa = DEC_IMM ? DEC_RD | IMM_BASE_IDX : DEC_RD;
	always_comb begin
		vec = '0;
		for (int i = IRQ_N - 1; i >= 0; i--) begin
			if (IRQ_REQ[i]) begin
				vec = PC_W'(i + 1);
			end
		end
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	a_seq_fetch: assert property (run && DEC_FLOW == 3'h0 |=>
		PM_ADDR == PC_OUT + 9'h001 && PC_OUT == $past(PM_ADDR))
		else $error("fetch did not advance");
	a_rel_target: assert property (run && DEC_FLOW inside {3'h1, 3'h2}
		|=> !INSN_VALID && PM_ADDR == $past(PC_OUT) + $past(koff) + 9'h001)
		else $error("relative target wrong");
	a_irq_entry: assert property (CE && INSN_VALID && irq_go && !GIE_SET
		|=> IRQ_TAKEN && !GIE && PM_ADDR == $past(vec))
		else $error("interrupt entry wrong");
	a_irq_gated: assert property (!GIE |=> !IRQ_TAKEN)
		else $error("interrupt taken while disabled");
	a_return_from_irq_enable: assert property (run && DEC_FLOW == 3'h4 |=> GIE)
		else $error("return did not enable");
	a_ptr_pair: assert property (IO_PTR == PTR[IO_AW-1:0])
		else $error("pointer views differ");
	a_ptr_write: assert property (run && DEC_WE && wa == PTR_LO_IDX
		##1 CE |=> PTR[REG_W-1:0] == $past(ALU_RESULT, 2))
		else $error("pointer low byte not written");
	a_squash_nop: assert property ($fell(INSN_VALID) |-> INSN == INSN_NOP)
		else $error("squashed word not empty");
	a_wb_visible: assert property (run && DEC_WE ##1 CE && DEC_RR == $past(wa)
		|=> OPB == $past(ALU_RESULT, 2))
		else $error("write-back not read");
	c_irq: cover property (IRQ_TAKEN);
	c_call: cover property (run && DEC_FLOW == 3'h2);
	c_ret: cover property (run && DEC_FLOW == 3'h3);
endmodule : crf_core_props
bind crf_core crf_core_props crf_core_props_inst (.*);
`default_nettype wire

/* File: testbench/crf_pmem_model.sv */
/* Program memory model: 512 words of 16 bits, read without a clock.
   Assumes the core captures the word at the edge that ends the fetch. */
`timescale 1ns/1ns
`default_nettype none
module crf_pmem_model
	import crf_pkg::*;
(
	input wire logic [PC_W-1:0] addr, // Fetch address.
	output logic [INSN_W-1:0] data // Word at addr, same cycle.
);
	// Each word carries its own address so fetch order shows at INSN.
	assign data = {7'h5A, addr};
endmodule : crf_pmem_model
`default_nettype wire

/* File: testbench/test_cpu_core_register_file_stack.sv */
/* Bench for the datapath core; it plays the decoder and ALU.
   Assumes crf_pmem_model serves the fetches. */
`timescale 1ns/1ns
`default_nettype none
module test_cpu_core_register_file_stack;
	import crf_pkg::*;
	logic clk = 0, rst = 1, ce = 1, imm = 0, we = 0, gs = 0, gc = 0;
	logic [1:0] src = 0;
	logic [4:0] rd = 0, rr = 0;
	logic [2:0] flow = 0;
	logic [11:0] k = 0;
	logic [7:0] alu = 0, irq = 0, opa, opb;
	logic [15:0] pmd, insn, ptr;
	logic [8:0] pma, pc, ra [4];
	logic [5:0] iop;
	logic ival, gie, itk;
	int failures = 0, total_checks = 0, cyc = 0;
	always #50 clk = ~clk;
	crf_pmem_model crf_pmem_model_inst (.addr(pma), .data(pmd));
	crf_core crf_core_inst (.CLK_SYS(clk), .RST(rst), .CE(ce), .PM_DATA(pmd),
		.DEC_SRC_A(src), .DEC_RD(rd), .DEC_RR(rr), .DEC_IMM(imm),
		.DEC_WE(we), .DEC_FLOW(flow), .DEC_K(k), .ALU_RESULT(alu),
		.IRQ_REQ(irq), .GIE_SET(gs), .GIE_CLR(gc), .PM_ADDR(pma),
		.INSN(insn), .INSN_VALID(ival), .OPA(opa), .OPB(opb), .PTR(ptr),
		.IO_PTR(iop), .PC_OUT(pc), .GIE(gie), .IRQ_TAKEN(itk));
	task automatic step;
		@(posedge clk);
		#1;
	endtask : step
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// Always spends a cycle, so no input is set twice in one time step.
	task automatic wv;
		step;
		for (int i = 0; i < 8 && ival !== 1'b1; i++) step;
	endtask : wv
	task automatic go;
		step;
		{flow, we, imm, src, irq, gs, gc} = '0;
	endtask : go
	function automatic logic [7:0] v(input int i);
		return 8'(i * 37 + 5);
	endfunction : v
	task automatic final_report;
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	always @(posedge clk) begin
		if (++cyc == 1000) begin
			failures++;
			final_report;
		end
	end
	task automatic t_reset;
		chk(pma, 0);
		rst = 0;
		wv;
		chk(insn, {7'h5A, pc});
		$display("reset done");
	endtask : t_reset
	task automatic t_regs;
		wv;
		we = 1;
		for (int i = 0; i < 32; i++) begin
			{rd, alu} = {5'(i), v(i)};
			step;
		end
		{ce, rd, alu} = {1'b0, 5'h00, 8'hEE};
		ra[2] = pma;
		ra[3] = pc;
		step;
		step;
		chk(pma, ra[2]);
		chk(pc, ra[3]);
		{ce, we} = 2'b10;
		for (int i = 0; i < 32; i++) begin
			{rr, rd} = {5'(i), 5'(31 - i)};
			step;
			chk(opb, v(i));
			chk(opa, v(31 - i));
		end
		$display("regs done");
	endtask : t_regs
	task automatic t_imm_ptr;
		wv;
		{imm, we, rd, rr, alu} = {2'b11, 5'h03, 5'h13, 8'h99};
		go;
		step;
		chk(opb, 8'h99);
		rr = 5'h03;
		step;
		chk(opb, v(3));
		{we, rd, alu} = {1'b1, 5'h1E, 8'h07};
		step;
		{rd, alu} = {5'h1F, 8'hAB};
		step;
		{we, src} = {1'b0, 2'h2};
		step;
		chk(ptr, 16'hAB07);
		chk(iop, 6'h07);
		step;
		chk(opa, v(7));
		src = 0;
		$display("imm ptr done");
	endtask : t_imm_ptr
	task automatic t_stack;
		wv;
		ra[0] = pc + 9'h001;
		{flow, k} = {3'h1, 12'h7FF};
		go;
		chk(pma, 9'(ra[0] + k));
		chk(ival, 0);
		chk(insn, INSN_NOP);
		for (int j = 0; j < 4; j++) begin
			wv;
			ra[j] = pc + 9'h001;
			{flow, k} = {3'h2, 12'(j * 300 - 200)};
			go;
			chk(pma, 9'(ra[j] + k));
		end
		for (int j = 3; j >= 0; j--) begin
			wv;
			flow = 3'h3;
			go;
			chk(pma, ra[j > 0 ? j : 1]);
		end
		$display("stack done");
	endtask : t_stack
	task automatic t_irq;
		wv;
		irq = 8'h06;
		go;
		chk(itk, 0);
		wv;
		gs = 1;
		go;
		wv;
		ra[0] = pc;
		irq = 8'h06;
		go;
		chk({itk, gie}, 2'b10);
		chk(pma, 9'h002);
		wv;
		flow = 3'h4;
		go;
		chk({pma, gie}, {ra[0], 1'b1});
		wv;
		gc = 1;
		go;
		chk(gie, 0);
		$display("irq done");
	endtask : t_irq
	initial begin
		repeat (6) step;
		t_reset;
		t_regs;
		t_imm_ptr;
		t_stack;
		t_irq;
		final_report;
	end
endmodule : test_cpu_core_register_file_stack
`default_nettype wire
